// ===== osc_core_pkg.sv
// shared constants and types for the oscillator and core-supply control block
package osc_core_pkg;
    localparam int CLOCK_MHZ = 40;
    localparam int CORE_SETTLE_TIME_US = 5000;
    localparam int FAST_OSC_STABLE_TIME_US = 20000;
    localparam int CORE_SETTLE_CYCLES = CORE_SETTLE_TIME_US * CLOCK_MHZ;
    localparam int FAST_OSC_STABLE_CYCLES = FAST_OSC_STABLE_TIME_US * CLOCK_MHZ;
    localparam int COUNT_W = 20;

    localparam logic [7:0] OSC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] CLKOUT_CTRL_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;

    localparam int OSC_CLK_SRC_BIT = 0;
    localparam int OSC_ENABLE_BIT = 1;
    localparam int OSC_VSEL_LO_BIT = 2;
    localparam int OSC_VSEL_HI_BIT = 3;

    localparam int OUT_PIN0_EN_BIT = 0;
    localparam int OUT_PIN0_SEL_BIT = 1;
    localparam int OUT_PIN1_EN_BIT = 2;
    localparam int OUT_PIN1_SEL_BIT = 3;
    localparam int OUT_PRESC_EN_BIT = 4;
    localparam int OUT_PDATA0_BIT = 5;
    localparam int OUT_PDATA1_BIT = 6;

    localparam int ST_OSC_ON_BIT = 0;
    localparam int ST_CORE_BUSY_BIT = 1;
    localparam int ST_OSC_STAB_BIT = 2;
    localparam int ST_PRESC_BIT = 3;

    localparam logic RESET_CLK_SRC = 1'b0;
    localparam logic RESET_OSC_EN = 1'b0;
    localparam logic [1:0] RESET_VSEL = 2'h0;
    localparam logic RESET_PDATA = 1'b1;

    typedef enum logic [0:0] {
        TIMER_IDLE = 1'b0,
        TIMER_RUN = 1'b1
    } timer_state_t;
endpackage

// ===== settle_if.sv
// start and busy pair between the controller and one settling timer
`timescale 1ns/1ps
interface settle_if;
    logic start;
    logic busy;
    modport owner (output start, input busy);
    modport timer (input start, output busy);
endinterface

// ===== settle_timer.sv
// one-shot settling interval counter
`timescale 1ns/1ps
module settle_timer #(
    parameter int COUNT = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    settle_if.timer link
);
    typedef struct packed {
        osc_core_pkg::timer_state_t state;
        logic [osc_core_pkg::COUNT_W-1:0] cnt;
    } tstate_t;

    tstate_t s;
    tstate_t next_s;

    always_comb begin
        next_s = s;
        if (link.start) begin
            next_s.state = osc_core_pkg::TIMER_RUN;
            next_s.cnt = '0;
        end else begin
            case (s.state)
                osc_core_pkg::TIMER_IDLE: begin
                    next_s.cnt = '0;
                end
                osc_core_pkg::TIMER_RUN: begin
                    if (s.cnt == osc_core_pkg::COUNT_W'(COUNT - 1)) begin
                        next_s.state = osc_core_pkg::TIMER_IDLE;
                    end else begin
                        next_s.cnt = s.cnt + 1'b1;
                    end
                end
                default: begin
                    next_s.state = osc_core_pkg::TIMER_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '{state: osc_core_pkg::TIMER_IDLE, cnt: '0};
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign link.busy = (s.state == osc_core_pkg::TIMER_RUN);
endmodule

// ===== osc_and_core_voltage_control.sv
// oscillator, core-supply and clock output control with an ahb-lite register slave
//
// Contract
// R1: reset selects slow oscillator, fast oscillator off, core code 00 (2.4 V).
// R2: software changes core level only while the fast oscillator is off.
// R3: software waits 5 ms after a level change before enabling fast oscillator.
// R4: software steps the core level one adjacent level at a time.
// R5: each single level step is followed by a 5 ms pause.
// R6: software allows 20 ms fast oscillator start-up before its peripherals run.
// R7: clock switch to slow and fast oscillator stop take two separate writes.
// R8: software halts fast-clocked peripherals before stopping the fast oscillator.
// R9: prescaler clock runs only while the fast oscillator is enabled.
// R10: software waits fast oscillator start-up before enabling prescaler output.
// R11: each clock pin carries one of its two sources, never both.
// R12: port data bit 0 holds its clock pin low regardless of output setting.
// R13: changing clock output setting may glitch the pin; no glitch guard.
// R14: software disables clock outputs before sleep.
// R15: software keeps the fast oscillator off when unused.
`timescale 1ns/1ps
module osc_and_core_voltage_control #(
    parameter int CORE_SETTLE_COUNT = osc_core_pkg::CORE_SETTLE_CYCLES,
    parameter int FAST_OSC_STABLE_COUNT = osc_core_pkg::FAST_OSC_STABLE_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic fast_divided_clock,
    input wire logic slow_divided_clock,
    input wire logic timer0_toggle_out,
    input wire logic timer1_toggle_out,
    output logic system_clock_source_select,
    output logic fast_oscillator_enable,
    output logic [1:0] core_voltage_select,
    output logic prescaler_clock_enable,
    output logic clock_pin0_out,
    output logic clock_pin1_out
);
    typedef struct packed {
        logic clk_src;
        logic osc_en;
        logic [1:0] vsel;
        logic pin0_en;
        logic pin0_sel;
        logic pin1_en;
        logic pin1_sel;
        logic presc_en;
        logic pdata0;
        logic pdata1;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        logic readyout;
        logic pin0;
        logic pin1;
        logic presc_clk_en;
        logic core_start;
        logic osc_start;
    } ctrl_t;

    ctrl_t s;
    ctrl_t next_s;

    settle_if core_link ();
    settle_if osc_link ();

    function automatic logic pin_drive(input logic pdata, input logic en, input logic sel,
                                       input logic src_a, input logic src_b);
        logic src;
        src = sel ? src_b : src_a;
        pin_drive = pdata & (en ? src : 1'b1);
    endfunction

    function automatic logic [31:0] read_word(input ctrl_t r, input logic core_busy,
                                              input logic osc_busy, input logic [7:0] addr);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (addr)
            osc_core_pkg::OSC_CTRL_ADDR: begin
                w[osc_core_pkg::OSC_CLK_SRC_BIT] = r.clk_src;
                w[osc_core_pkg::OSC_ENABLE_BIT] = r.osc_en;
                w[osc_core_pkg::OSC_VSEL_HI_BIT:osc_core_pkg::OSC_VSEL_LO_BIT] = r.vsel;
            end
            osc_core_pkg::CLKOUT_CTRL_ADDR: begin
                w[osc_core_pkg::OUT_PIN0_EN_BIT] = r.pin0_en;
                w[osc_core_pkg::OUT_PIN0_SEL_BIT] = r.pin0_sel;
                w[osc_core_pkg::OUT_PIN1_EN_BIT] = r.pin1_en;
                w[osc_core_pkg::OUT_PIN1_SEL_BIT] = r.pin1_sel;
                w[osc_core_pkg::OUT_PRESC_EN_BIT] = r.presc_en;
                w[osc_core_pkg::OUT_PDATA0_BIT] = r.pdata0;
                w[osc_core_pkg::OUT_PDATA1_BIT] = r.pdata1;
            end
            osc_core_pkg::STATUS_ADDR: begin
                w[osc_core_pkg::ST_OSC_ON_BIT] = r.osc_en;
                w[osc_core_pkg::ST_CORE_BUSY_BIT] = core_busy;
                w[osc_core_pkg::ST_OSC_STAB_BIT] = osc_busy;
                w[osc_core_pkg::ST_PRESC_BIT] = r.presc_en & r.osc_en;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        read_word = w;
    endfunction

    always_comb begin
        next_s = s;
        next_s.core_start = 1'b0;
        next_s.osc_start = 1'b0;
        next_s.readyout = 1'b1;
        // data phase of a write lands here
        if (s.dp_valid && s.dp_write) begin
            case (s.dp_addr)
                osc_core_pkg::OSC_CTRL_ADDR: begin
                    // both fields may change in one write; sequencing is software's [R7]
                    next_s.clk_src = hwdata[osc_core_pkg::OSC_CLK_SRC_BIT];
                    next_s.osc_en = hwdata[osc_core_pkg::OSC_ENABLE_BIT];
                    next_s.vsel =
                        hwdata[osc_core_pkg::OSC_VSEL_HI_BIT:osc_core_pkg::OSC_VSEL_LO_BIT];
                    // level change starts the settling interval [R3] [R5]
                    if (next_s.vsel != s.vsel) begin
                        next_s.core_start = 1'b1;
                    end
                    // fast oscillator turn-on starts the start-up interval [R6] [R10]
                    if (next_s.osc_en && !s.osc_en) begin
                        next_s.osc_start = 1'b1;
                    end
                end
                osc_core_pkg::CLKOUT_CTRL_ADDR: begin
                    next_s.pin0_en = hwdata[osc_core_pkg::OUT_PIN0_EN_BIT];
                    next_s.pin0_sel = hwdata[osc_core_pkg::OUT_PIN0_SEL_BIT];
                    next_s.pin1_en = hwdata[osc_core_pkg::OUT_PIN1_EN_BIT];
                    next_s.pin1_sel = hwdata[osc_core_pkg::OUT_PIN1_SEL_BIT];
                    next_s.presc_en = hwdata[osc_core_pkg::OUT_PRESC_EN_BIT];
                    next_s.pdata0 = hwdata[osc_core_pkg::OUT_PDATA0_BIT];
                    next_s.pdata1 = hwdata[osc_core_pkg::OUT_PDATA1_BIT];
                end
                default: begin
                    next_s.dp_write = 1'b0;
                end
            endcase
        end
        // address phase capture
        if (hready) begin
            next_s.dp_valid = hsel & htrans[1];
            next_s.dp_write = hwrite;
            next_s.dp_addr = haddr[7:0];
            if (hsel && htrans[1] && !hwrite) begin
                next_s.rdata = read_word(next_s, core_link.busy, osc_link.busy, haddr[7:0]);
            end
        end
        // prescaler clock gated by the fast oscillator [R9]
        next_s.presc_clk_en = next_s.presc_en & next_s.osc_en;
        // one source per pin by select, data bit 0 forces low, no glitch guard [R11] [R12] [R13]
        next_s.pin0 = pin_drive(next_s.pdata0, next_s.pin0_en, next_s.pin0_sel,
                                fast_divided_clock, timer0_toggle_out);
        next_s.pin1 = pin_drive(next_s.pdata1, next_s.pin1_en, next_s.pin1_sel,
                                slow_divided_clock, timer1_toggle_out);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '0;
            // slow source, fast oscillator off, core code 00 [R1]
            s.clk_src <= osc_core_pkg::RESET_CLK_SRC;
            s.osc_en <= osc_core_pkg::RESET_OSC_EN;
            s.vsel <= osc_core_pkg::RESET_VSEL;
            s.pdata0 <= osc_core_pkg::RESET_PDATA;
            s.pdata1 <= osc_core_pkg::RESET_PDATA;
            s.pin0 <= osc_core_pkg::RESET_PDATA;
            s.pin1 <= osc_core_pkg::RESET_PDATA;
            s.readyout <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign core_link.start = s.core_start;
    assign osc_link.start = s.osc_start;

    settle_timer #(
        .COUNT(CORE_SETTLE_COUNT)
    ) core_settle (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .link(core_link)
    );

    settle_timer #(
        .COUNT(FAST_OSC_STABLE_COUNT)
    ) osc_settle (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .link(osc_link)
    );

    assign hrdata = s.rdata;
    assign hreadyout = s.readyout;
    assign hresp = 1'b0;
    assign system_clock_source_select = s.clk_src;
    assign fast_oscillator_enable = s.osc_en;
    assign core_voltage_select = s.vsel;
    assign prescaler_clock_enable = s.presc_clk_en;
    assign clock_pin0_out = s.pin0;
    assign clock_pin1_out = s.pin1;
endmodule

// ===== osc_and_core_voltage_control_asserts.sv
// port assertions for the oscillator and clock output control block
`timescale 1ns/1ps
module osc_and_core_voltage_control_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic fast_divided_clock,
    input wire logic slow_divided_clock,
    input wire logic timer0_toggle_out,
    input wire logic timer1_toggle_out,
    input wire logic system_clock_source_select,
    input wire logic fast_oscillator_enable,
    input wire logic [1:0] core_voltage_select,
    input wire logic prescaler_clock_enable,
    input wire logic clock_pin0_out,
    input wire logic clock_pin1_out
);
    logic dp_wr;
    logic [6:0] out_sh;
    wire ap = ce && hready && hsel && htrans[1];
    // shadow of the clock output control word
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dp_wr <= 1'h0;
            out_sh <= 7'h60;
        end else if (ce) begin
            if (dp_wr) begin
                out_sh <= hwdata[6:0];
            end
            dp_wr <= ap && hwrite && haddr[7:0] == osc_core_pkg::CLKOUT_CTRL_ADDR;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_osc_wr;
        ap && hwrite && haddr[7:0] == osc_core_pkg::OSC_CTRL_ADDR ##1 ce;
    endsequence
    property p_osc_wr;
        s_osc_wr |=> core_voltage_select == $past(hwdata[3:2])
            && fast_oscillator_enable == $past(hwdata[1])
            && system_clock_source_select == $past(hwdata[0]);
    endproperty
    property p_reset;
        $past(rst_n) == 1'h0 |-> !system_clock_source_select && !fast_oscillator_enable
            && core_voltage_select == 2'h0 && !prescaler_clock_enable;
    endproperty
    property p_bus;
        hreadyout && !hresp;
    endproperty
    property p_presc;
        prescaler_clock_enable == (out_sh[4] && fast_oscillator_enable);
    endproperty
    property p_pin0_low;
        !out_sh[5] |-> !clock_pin0_out;
    endproperty
    property p_pin1_low;
        !out_sh[6] |-> !clock_pin1_out;
    endproperty
    property p_pin0_src;
        out_sh[5] && out_sh[0] |-> clock_pin0_out ==
            (out_sh[1] ? $past(timer0_toggle_out) : $past(fast_divided_clock));
    endproperty
    property p_pin1_src;
        out_sh[6] && out_sh[2] |-> clock_pin1_out ==
            (out_sh[3] ? $past(timer1_toggle_out) : $past(slow_divided_clock));
    endproperty
    a_osc_wr: assert property (p_osc_wr) else $error("control write not applied");
    a_reset: assert property (p_reset) else $error("reset levels wrong");
    a_bus: assert property (p_bus) else $error("bus answer not ready or okay");
    a_presc: assert property (p_presc) else $error("prescaler gate wrong");
    a_pin0_low: assert property (p_pin0_low) else $error("pin0 not held low");
    a_pin1_low: assert property (p_pin1_low) else $error("pin1 not held low");
    a_pin0_src: assert property (p_pin0_src) else $error("pin0 source wrong");
    a_pin1_src: assert property (p_pin1_src) else $error("pin1 source wrong");
endmodule
bind osc_and_core_voltage_control osc_and_core_voltage_control_asserts u_chk (.clock, .rst_n,
    .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
    .fast_divided_clock, .slow_divided_clock, .timer0_toggle_out, .timer1_toggle_out,
    .system_clock_source_select, .fast_oscillator_enable, .core_voltage_select,
    .prescaler_clock_enable, .clock_pin0_out, .clock_pin1_out);

// ===== osc_and_core_voltage_control_tb.sv
// self-checking bench for the oscillator and clock output control block
`timescale 1ns/1ps
module osc_and_core_voltage_control_tb;
    logic clock, rst_n, ce, hsel, hwrite, hready, hreadyout, hresp, rd_dp;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans, vsel;
    logic [2:0] hsize;
    logic fdc, sdc, t0, t1, src_sel, osc_en, presc, pin0, pin1;
    logic [31:0] exp_q[$];
    int seed = 20;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    assign hready = hreadyout;
    osc_and_core_voltage_control #(.CORE_SETTLE_COUNT(20), .FAST_OSC_STABLE_COUNT(50)) dut (
        .clock(clock), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .fast_divided_clock(fdc),
        .slow_divided_clock(sdc), .timer0_toggle_out(t0), .timer1_toggle_out(t1),
        .system_clock_source_select(src_sel), .fast_oscillator_enable(osc_en),
        .core_voltage_select(vsel), .prescaler_clock_enable(presc),
        .clock_pin0_out(pin0), .clock_pin1_out(pin1));
    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // release reset after n edges, then look at the outputs off the edge
    task automatic reset_check(input int n);
        repeat (n) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        @(negedge clock);
        chk(32'({src_sel, osc_en, vsel, presc, pin0, pin1}), 32'h3);
        @(posedge clock);
    endtask
    // one single ahb-lite transfer; reads note their expected word
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        @(posedge clock);
        while (hreadyout !== 1'h1) @(posedge clock);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        if (!wr) exp_q.push_back(d);
        @(posedge clock);
        while (hreadyout !== 1'h1) @(posedge clock);
    endtask
    // read data checker and random clock sources
    always @(posedge clock) begin
        cycles++;
        {fdc, sdc, t0, t1} <= 4'($random(seed));
        if (rd_dp === 1'h1) chk(hrdata, exp_q.pop_front());
        rd_dp <= rst_n && hsel && htrans[1] && !hwrite && hreadyout;
        if (cycles == 3000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        rst_n = 1'h0;
        ce = 1'h1;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = {1'h0, 1'h0, 2'h0, 3'h2, 64'h0};
        {fdc, sdc, t0, t1} = 4'h0;
        reset_check(16);
        xfer(1'h0, 8'h00, 32'h0);
        xfer(1'h0, 8'h04, 32'h60);
        xfer(1'h0, 8'h08, 32'h0);
        xfer(1'h1, 8'h0C, 32'hF);
        xfer(1'h0, 8'h0C, 32'h0);
        $display("test reset done");
        xfer(1'h1, 8'h00, 32'h4);
        repeat (2) @(posedge clock);
        xfer(1'h0, 8'h08, 32'h2);
        xfer(1'h0, 8'h00, 32'h4);
        repeat (25) @(posedge clock);
        xfer(1'h0, 8'h08, 32'h0);
        xfer(1'h1, 8'h00, 32'h6);
        repeat (2) @(posedge clock);
        xfer(1'h0, 8'h08, 32'h5);
        repeat (55) @(posedge clock);
        xfer(1'h0, 8'h08, 32'h1);
        $display("test core step and start-up done");
        xfer(1'h1, 8'h04, 32'h70);
        xfer(1'h0, 8'h08, 32'h9);
        chk(32'(presc), 32'h1);
        xfer(1'h1, 8'h00, 32'h7);
        xfer(1'h1, 8'h00, 32'h6);
        xfer(1'h1, 8'h04, 32'h60);
        xfer(1'h1, 8'h00, 32'h4);
        xfer(1'h1, 8'h04, 32'h70);
        xfer(1'h0, 8'h08, 32'h0);
        chk(32'(presc), 32'h0);
        $display("test prescaler gate done");
        xfer(1'h1, 8'h04, 32'h0F);
        repeat (4) begin
            @(negedge clock);
            chk(32'({pin0, pin1}), 32'h0);
        end
        @(posedge clock);
        repeat (8) begin
            v = 32'($random(seed)) & 32'h7F;
            xfer(1'h1, 8'h04, v);
            xfer(1'h0, 8'h04, v);
            repeat (6) @(posedge clock);
        end
        xfer(1'h1, 8'h04, 32'h60);
        @(negedge clock);
        chk(32'({pin0, pin1}), 32'h3);
        @(posedge clock);
        $display("test clock outputs done");
        xfer(1'h1, 8'h00, 32'h0);
        ce <= 1'h0;
        repeat (30) @(posedge clock);
        ce <= 1'h1;
        @(posedge clock);
        xfer(1'h0, 8'h08, 32'h2);
        rst_n <= 1'h0;
        reset_check(2);
        xfer(1'h0, 8'h00, 32'h0);
        xfer(1'h0, 8'h04, 32'h60);
        xfer(1'h0, 8'h08, 32'h0);
        $display("test freeze and reset done");
        close_out();
    end
endmodule
